// ==== logic/dae_diag.sv ====
// alarm flags, diagnostic objects and emergency frame sender
`timescale 1ns/1ps
module dae_diag
  import dae_pkg::*;
#(
  parameter int CLK_HZ = dae_pkg::CLK_HZ_NOM,
  parameter logic [31:0] FW_REV = 32'h31302e30,    // arbitrary value
  parameter logic [31:0] UNIT_SERIAL = 32'h0000_0001, // arbitrary value
  parameter logic [15:0] EMCY_CODE = 16'h1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // measurement conditions
  input wire logic [7:0] intensity_pct,
  input wire logic beam_lost,
  input wire logic signed [7:0] temp_c,
  input wire logic hw_fault,
  input wire logic laser_off_cmd,
  input wire logic laser_off_pin,
  input wire logic emitter_on,
  input wire logic speed_chk_en,
  input wire logic speed_over,
  input wire logic plaus_fail,
  // preset result
  input wire logic preset_load,
  input wire logic [31:0] preset_offset_in,
  // object read port
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  output logic obj_rvalid,
  output logic obj_unmapped,
  output logic [31:0] obj_rdata,
  // emergency frame port
  input wire logic [6:0] node_id,
  input wire logic auto_ack,
  input wire logic master_ack,
  output logic emcy_valid,
  input wire logic emcy_ready,
  output logic [10:0] emcy_id,
  output logic [63:0] emcy_data,
  // status
  output logic pos_error,
  output logic [15:0] stored_code
);
  import dae_pkg::*;

  localparam logic [31:0] CYC_PER_SEC_M1 = 32'(CLK_HZ - 1);

  if (CLK_HZ < 1) begin : g_chk_clk
    $error("CLK_HZ must be positive");
  end

  logic laser_off_sync;
  logic [15:0] alarm_d;
  logic [15:0] alarm_q;
  logic err_now;
  logic err_prev_q;
  logic err_rise;
  logic err_fall;
  logic err_pend_q;
  logic clr_pend_q;
  logic take_err;
  logic take_clr;
  dae_emcy_state_t em_state_q;
  logic [31:0] preset_q;
  logic [31:0] sec_cnt_q;
  logic [11:0] sec_in_hr_q;
  logic [31:0] hours_q;
  logic [15:0] rd_idx_q;

  // pin input filter
  dae_sync u_sync_laser_off (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(laser_off_pin),
    .level_out(laser_off_sync)
  );

  // alarm bit conditions
  always_comb begin
    alarm_d = ALARM_NONE;
    alarm_d[ALM_INTENS] = beam_lost || (intensity_pct < INTENS_ERR_PCT);
    alarm_d[ALM_TEMP] = (temp_c < TEMP_MIN_C) || (temp_c > TEMP_MAX_C);
    alarm_d[ALM_HW] = hw_fault;
    alarm_d[ALM_LASER_OFF] = laser_off_cmd || laser_off_sync;
    alarm_d[ALM_INTENS_WARN] = intensity_pct < INTENS_WARN_PCT;
    alarm_d[ALM_SPEED] = speed_chk_en && speed_over;
    alarm_d[ALM_PLAUS] = plaus_fail;
  end

  // whole alarm word taken in one edge, held while the cause lasts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_q <= ALARM_NONE;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // position replaced by error value on intensity and hardware error bits only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_error <= 1'b0;
    end else begin
      pos_error <= alarm_d[ALM_INTENS] || alarm_d[ALM_HW];
    end
  end

  // internal error edges
  assign err_now = alarm_q[ALM_INTENS] || alarm_q[ALM_TEMP] || alarm_q[ALM_HW];
  assign err_rise = err_now && !err_prev_q;
  assign err_fall = !err_now && err_prev_q;
  assign take_err = (em_state_q == EM_IDLE) && err_pend_q;
  assign take_clr = (em_state_q == EM_IDLE) && !err_pend_q && clr_pend_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_prev_q <= 1'b0;
    end else begin
      err_prev_q <= err_now;
    end
  end

  // pending frames, a new event wins over the take
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_pend_q <= 1'b0;
      clr_pend_q <= 1'b0;
    end else begin
      if (err_rise) begin
        err_pend_q <= 1'b1;
      end else if (take_err) begin
        err_pend_q <= 1'b0;
      end
      if (err_rise) begin
        clr_pend_q <= 1'b0;
      end else if (err_fall && auto_ack) begin
        clr_pend_q <= 1'b1;
      end else if (take_clr) begin
        clr_pend_q <= 1'b0;
      end
    end
  end

  // emergency frame sender
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      em_state_q <= EM_IDLE;
      emcy_data <= 64'h0000_0000_0000_0000;
      emcy_id <= EMCY_BASE_ID;
    end else begin
      case (em_state_q)
        EM_IDLE: begin
          if (take_err) begin
            emcy_data <= {40'h00_0000_0000, ERR_REG_GENERIC, EMCY_CODE};
            emcy_id <= EMCY_BASE_ID + {4'h0, node_id};
            em_state_q <= EM_SEND;
          end else if (take_clr) begin
            emcy_data <= {40'h00_0000_0000, ERR_REG_NONE, EMCY_CODE_NONE};
            emcy_id <= EMCY_BASE_ID + {4'h0, node_id};
            em_state_q <= EM_SEND;
          end
        end
        EM_SEND: begin
          if (emcy_ready) begin
            em_state_q <= EM_IDLE;
          end
        end
        default: begin
          em_state_q <= EM_IDLE;
        end
      endcase
    end
  end

  assign emcy_valid = (em_state_q == EM_SEND);

  // stored error code, reset by auto or master acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stored_code <= EMCY_CODE_NONE;
    end else if (err_rise) begin
      stored_code <= EMCY_CODE;
    end else if (err_fall && auto_ack) begin
      stored_code <= EMCY_CODE_NONE;
    end else if (!auto_ack && master_ack && !err_now) begin
      stored_code <= EMCY_CODE_NONE;
    end
  end

  // preset offset store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preset_q <= ZERO_WORD;
    end else if (preset_load) begin
      preset_q <= preset_offset_in;
    end
  end

  // emitter hour counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt_q <= ZERO_WORD;
      sec_in_hr_q <= 12'h000;
      hours_q <= ZERO_WORD;
    end else if (emitter_on) begin
      if (sec_cnt_q == CYC_PER_SEC_M1) begin
        sec_cnt_q <= ZERO_WORD;
        if (sec_in_hr_q == SEC_PER_HOUR_M1) begin
          sec_in_hr_q <= 12'h000;
          hours_q <= hours_q + 32'h0000_0001;
        end else begin
          sec_in_hr_q <= sec_in_hr_q + 12'h001;
        end
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
      end
    end
  end

  // object read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      obj_rvalid <= 1'b0;
      obj_unmapped <= 1'b0;
      obj_rdata <= ZERO_WORD;
      rd_idx_q <= 16'h0000;
    end else begin
      obj_rvalid <= obj_rd;
      if (obj_rd) begin
        rd_idx_q <= obj_index;
        obj_unmapped <= 1'b0;
        case (obj_index)
          IDX_ALARM: obj_rdata <= {16'h0000, 8'h00, alarm_q[7:0]};
          IDX_SUPP_ALARM: obj_rdata <= {16'h0000, SUPP_ALARM_VAL};
          IDX_WARN: obj_rdata <= ZERO_WORD;
          IDX_SUPP_WARN: obj_rdata <= ZERO_WORD;
          IDX_FW_REV: obj_rdata <= FW_REV;
          IDX_HOURS: obj_rdata <= hours_q;
          IDX_PRESET: obj_rdata <= preset_q;
          IDX_FACT_OFS: obj_rdata <= ZERO_WORD;
          IDX_SERIAL: obj_rdata <= UNIT_SERIAL;
          default: begin
            obj_rdata <= ZERO_WORD;
            obj_unmapped <= 1'b1;
          end
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_err_taken;
    err_rise && (em_state_q == EM_IDLE);
  endsequence

  sequence s_err_frame;
    emcy_valid && (emcy_data[15:0] == EMCY_CODE) && alarm_q[ALM_HW:ALM_INTENS] != 3'h0;
  endsequence

  a_alarm_idle_zero: assert property (
    (alarm_d == ALARM_NONE) |=> (alarm_q == ALARM_NONE))
    else $error("alarm word not zero without causes");

  a_intens_err_bit: assert property (
    (intensity_pct < INTENS_ERR_PCT) |=> alarm_q[ALM_INTENS] && pos_error)
    else $error("low intensity did not raise error and replace position");

  a_temp_range_bit: assert property (
    (temp_c > TEMP_MAX_C || temp_c < TEMP_MIN_C) |=> alarm_q[ALM_TEMP])
    else $error("temperature excursion not flagged");

  a_hw_pos_err: assert property (
    hw_fault |=> alarm_q[ALM_HW] && pos_error)
    else $error("hardware fault did not replace position");

  a_warn_no_pos: assert property (
    (intensity_pct >= INTENS_ERR_PCT && intensity_pct < INTENS_WARN_PCT && !beam_lost
     && !hw_fault) |=> alarm_q[ALM_INTENS_WARN] && !pos_error)
    else $error("cleaning warning wrongly handled");

  a_speed_disabled: assert property (
    !speed_chk_en |=> !alarm_q[ALM_SPEED])
    else $error("speed bit set while check disabled");

  a_supp_read: assert property (
    obj_rd && (obj_index == IDX_SUPP_ALARM) |=> obj_rvalid && (obj_rdata == 32'h0000_001f))
    else $error("supported alarm mask wrong");

  a_zero_objects: assert property (
    obj_rvalid && (rd_idx_q == IDX_WARN || rd_idx_q == IDX_SUPP_WARN
     || rd_idx_q == IDX_FACT_OFS) |-> (obj_rdata == ZERO_WORD))
    else $error("unsupported object not zero");

  a_emcy_layout: assert property (
    emcy_valid |-> (emcy_data[63:24] == 40'h00_0000_0000)
     && (emcy_id == EMCY_BASE_ID + {4'h0, node_id}))
    else $error("emergency frame layout or identifier wrong");

  a_emcy_with_alarm: assert property (
    s_err_taken ##1 !err_rise [*1] |-> ##1 s_err_frame)
    else $error("error frame not sent with alarm bit");

  a_emcy_hold: assert property (
    emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_data))
    else $error("emergency frame dropped under back-pressure");

  a_clear_frame: assert property (
    err_fall && auto_ack && (em_state_q == EM_IDLE) && !err_pend_q && !err_rise
     |=> ##1 emcy_valid && (emcy_data[23:0] == 24'h00_0000))
    else $error("clear frame not sent after error cleared");
endmodule : dae_diag

// ==== common/dae_pkg.sv ====
// constants and types of the alarm and emergency diagnostic block
package dae_pkg;
  // object indices of the readable diagnostic objects
  localparam logic [15:0] IDX_ALARM = 16'h6503;
  localparam logic [15:0] IDX_SUPP_ALARM = 16'h6504;
  localparam logic [15:0] IDX_WARN = 16'h6505;
  localparam logic [15:0] IDX_SUPP_WARN = 16'h6506;
  localparam logic [15:0] IDX_FW_REV = 16'h6507;
  localparam logic [15:0] IDX_HOURS = 16'h6508;
  localparam logic [15:0] IDX_PRESET = 16'h6509;
  localparam logic [15:0] IDX_FACT_OFS = 16'h650a;
  localparam logic [15:0] IDX_SERIAL = 16'h650b;

  // alarm bit positions in the low byte
  localparam int ALM_INTENS = 0;
  localparam int ALM_TEMP = 1;
  localparam int ALM_HW = 2;
  localparam int ALM_LASER_OFF = 3;
  localparam int ALM_INTENS_WARN = 4;
  localparam int ALM_SPEED = 5;
  localparam int ALM_PLAUS = 6;

  // fixed read values and reset values
  localparam logic [15:0] SUPP_ALARM_VAL = 16'h001f;
  localparam logic [15:0] ALARM_NONE = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] EMCY_CODE_NONE = 16'h0000;
  localparam logic [7:0] ERR_REG_NONE = 8'h00;
  localparam logic [7:0] ERR_REG_GENERIC = 8'h01;

  // thresholds
  localparam logic [7:0] INTENS_ERR_PCT = 8'h08;
  localparam logic [7:0] INTENS_WARN_PCT = 8'h0c;
  localparam logic signed [7:0] TEMP_MIN_C = 8'sh00;
  localparam logic signed [7:0] TEMP_MAX_C = 8'sh32;

  // emergency frame identifier base
  localparam logic [10:0] EMCY_BASE_ID = 11'h080;

  // timing
  localparam int CLK_HZ_NOM = 125_000_000;
  localparam int HOUR_S = 3600;
  localparam logic [11:0] SEC_PER_HOUR_M1 = 12'(HOUR_S - 1);

  typedef enum logic [1:0] {EM_IDLE, EM_SEND} dae_emcy_state_t;
endpackage : dae_pkg

// ==== logic/dae_sync.sv ====
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module dae_sync (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule : dae_sync

// ==== tb/dae_master_model.sv ====
// emergency frame sink standing in for the network master
`timescale 1ns/1ps
module dae_master_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // frame handshake
  input wire logic emcy_valid,
  output logic emcy_ready,
  // stall mode
  input wire logic slow
);
  logic [2:0] cnt_q;
  // accepts every cycle, or on the eighth offered cycle when stalling
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      emcy_ready <= 1'b0;
    end else begin
      cnt_q <= emcy_valid ? cnt_q + 3'h1 : 3'h0;
      emcy_ready <= !slow || (cnt_q == 3'h6);
    end
  end
endmodule : dae_master_model

// ==== tb/tb_top.sv ====
// self-checking bench of the diagnostic block
`timescale 1ns/1ps
module tb_top;
  import dae_pkg::*;
  localparam logic [15:0] E_CODE = 16'h1000;
  localparam logic [31:0] FW = 32'h332e3034; // arbitrary value
  localparam logic [31:0] SER = 32'ha5c31e07; // arbitrary value
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] intensity_pct = 8'h32;
  logic signed [7:0] temp_c = 8'sd25;
  logic beam_lost = 1'b0, hw_fault = 1'b0, laser_off_cmd = 1'b0, laser_off_pin = 1'b0;
  logic emitter_on = 1'b0, speed_chk_en = 1'b0, speed_over = 1'b0, plaus_fail = 1'b0;
  logic preset_load = 1'b0, obj_rd = 1'b0, auto_ack = 1'b0, master_ack = 1'b0, slow = 1'b0;
  logic [31:0] preset_offset_in = 32'h0;
  logic [15:0] obj_index = 16'h0;
  logic [6:0] node_id = 7'h0;
  logic obj_rvalid, obj_unmapped, emcy_valid, emcy_ready, pos_error;
  logic [31:0] obj_rdata;
  logic [10:0] emcy_id;
  logic [63:0] emcy_data;
  logic [15:0] stored_code;
  logic [32:0] rd_q[$];
  logic [74:0] fr_q[$];
  logic [15:0] idx_t [10];
  logic [32:0] exv_t [10];
  logic [31:0] seed = 32'h6f70;
  logic [6:0] nid;
  int failures = 0;
  int total_checks = 0;
  int b;

  always #4 clk = ~clk;

  dae_diag #(.CLK_HZ(4), .FW_REV(FW), .UNIT_SERIAL(SER), .EMCY_CODE(E_CODE)) dae_diag_i (
    .clk(clk), .arst_n(arst_n), .intensity_pct(intensity_pct), .beam_lost(beam_lost),
    .temp_c(temp_c), .hw_fault(hw_fault), .laser_off_cmd(laser_off_cmd),
    .laser_off_pin(laser_off_pin), .emitter_on(emitter_on), .speed_chk_en(speed_chk_en),
    .speed_over(speed_over), .plaus_fail(plaus_fail), .preset_load(preset_load),
    .preset_offset_in(preset_offset_in), .obj_rd(obj_rd), .obj_index(obj_index),
    .obj_rvalid(obj_rvalid), .obj_unmapped(obj_unmapped), .obj_rdata(obj_rdata),
    .node_id(node_id), .auto_ack(auto_ack), .master_ack(master_ack),
    .emcy_valid(emcy_valid), .emcy_ready(emcy_ready), .emcy_id(emcy_id),
    .emcy_data(emcy_data), .pos_error(pos_error), .stored_code(stored_code));

  dae_master_model dae_master_model_i (
    .clk(clk), .arst_n(arst_n), .emcy_valid(emcy_valid), .emcy_ready(emcy_ready),
    .slow(slow));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [74:0] seen, input logic [74:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    failures += rd_q.size() + fr_q.size();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic rd(input logic [15:0] idx, input logic [32:0] exp);
    @(posedge clk);
    obj_rd <= 1'b1;
    obj_index <= idx;
    rd_q.push_back(exp);
    @(posedge clk);
    obj_rd <= 1'b0;
  endtask : rd

  // drive one alarm cause; case 7 is the filtered switching input
  task automatic cause(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: beam_lost <= v;
      1: temp_c <= v ? 8'sd51 : 8'sd25;
      2: hw_fault <= v;
      3: laser_off_cmd <= v;
      4: intensity_pct <= v ? 8'h08 : 8'h32;
      5: speed_over <= v;
      6: plaus_fail <= v;
      default: laser_off_pin <= v;
    endcase
  endtask : cause

  task automatic wait_frames();
    for (int n = 0; n < 300 && fr_q.size() != 0; n++) @(posedge clk);
    if (fr_q.size() != 0) begin
      failures++;
      tally_and_finish();
    end
    @(negedge clk);
  endtask : wait_frames

  // watcher: each result takes the oldest note off its queue
  always @(negedge clk) begin
    if (obj_rvalid === 1'b1) begin
      if (rd_q.size() == 0) check(75'({obj_unmapped, obj_rdata}), '1);
      else check(75'({obj_unmapped, obj_rdata}), 75'(rd_q.pop_front()));
    end
    if (emcy_valid === 1'b1 && emcy_ready === 1'b1) begin
      if (fr_q.size() == 0) check({emcy_id, emcy_data}, '1);
      else check({emcy_id, emcy_data}, fr_q.pop_front());
    end
  end

  initial begin
    idx_t = '{IDX_ALARM, IDX_SUPP_ALARM, IDX_WARN, IDX_SUPP_WARN, IDX_FW_REV, IDX_HOURS,
              IDX_FACT_OFS, IDX_SERIAL, 16'h6502, 16'h650c};
    exv_t = '{33'h0, 33'h1f, 33'h0, 33'h0, {1'b0, FW}, 33'h0, 33'h0, {1'b0, SER},
              33'h1_0000_0000, 33'h1_0000_0000};
    seed = lfsr(seed);
    nid = seed[6:0];
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    node_id <= nid;
    // back-to-back reads over every object except the preset, and two unmapped neighbours
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      obj_rd <= 1'b1;
      obj_index <= idx_t[i];
      rd_q.push_back(exv_t[i]);
    end
    @(posedge clk);
    obj_rd <= 1'b0;
    $display("test object table done");
    speed_over <= 1'b1;
    rd(IDX_ALARM, 33'h0); // overspeed ignored while the check is off
    speed_over <= 1'b0;
    auto_ack <= 1'b1;
    speed_chk_en <= 1'b1;
    slow <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      b = (k == 7) ? 3 : k;
      cause(k, 1'b1);
      if (b < 3) fr_q.push_back({11'h080 + 11'(nid), 40'h0, ERR_REG_GENERIC, E_CODE});
      repeat (12) @(posedge clk);
      @(negedge clk);
      check(75'(pos_error), 75'(b == 0 || b == 2));
      rd(IDX_ALARM, 33'(1 << b)); // alarm bit value checked by the watcher
      cause(k, 1'b0);
      if (b < 3) fr_q.push_back({11'h080 + 11'(nid), 64'h0});
      repeat (6) @(posedge clk);
      rd(IDX_ALARM, 33'h0);
      wait_frames();
      check(75'(stored_code), 75'(EMCY_CODE_NONE));
    end
    $display("test alarm bits done");
    seed = lfsr(seed);
    @(posedge clk);
    preset_offset_in <= seed;
    preset_load <= 1'b1;
    @(posedge clk);
    preset_load <= 1'b0;
    rd(IDX_PRESET, {1'b0, seed}); // preset offset kept
    $display("test preset done");
    auto_ack <= 1'b0;
    cause(2, 1'b1);
    fr_q.push_back({11'h080 + 11'(nid), 40'h0, ERR_REG_GENERIC, E_CODE});
    repeat (12) @(posedge clk);
    cause(2, 1'b0);
    repeat (20) @(posedge clk);
    wait_frames();
    check(75'(stored_code), 75'(E_CODE));
    @(posedge clk);
    master_ack <= 1'b1; // master acknowledges the stored code
    @(posedge clk);
    master_ack <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(75'(stored_code), 75'(EMCY_CODE_NONE));
    $display("test manual acknowledge done");
    @(posedge clk);
    emitter_on <= 1'b1;
    repeat (14398) @(posedge clk);
    rd(IDX_HOURS, 33'h0); // sampled on the edge that completes the hour, before the count moves
    rd(IDX_HOURS, 33'h1); // one emitter hour at four cycles a second
    repeat (3) @(posedge clk);
    $display("test emitter hours done");
    tally_and_finish();
  end
endmodule : tb_top
